// *** pkg/exec_ops_map.vh ***
`ifndef EXEC_OPS_MAP_VH
`define EXEC_OPS_MAP_VH

// opcodes
`define OP_PUSH 8'hC0
`define OP_SUB_EXIT 8'h22
`define OP_INT_EXIT 8'h32
`define OP_ROT_L 8'h23
`define OP_ROT_LC 8'h33
`define OP_ROT_R 8'h03
`define OP_ROT_RC 8'h13
`define OP_SET_BIT_OP_C 8'hD3
`define OP_SET_BIT_OP_BIT 8'hD2
`define OP_SHORT_RELATIVE_JUMP 8'h80
`define OP_SUBTRACT_WITH_BORROW_IMM 8'h94
`define OP_SUBTRACT_WITH_BORROW_DIR 8'h95
`define OP_SUBTRACT_WITH_BORROW_IND0 8'h96
`define OP_SUBTRACT_WITH_BORROW_IND1 8'h97
`define OP_SUBTRACT_WITH_BORROW_REG_HI 5'h13

// source operand modes for subtract and push
`define SRC_REG 2'h0
`define SRC_DIR 2'h1
`define SRC_IND 2'h2
`define SRC_IMM 2'h3

// reset values
`define SP_RST 8'h07
`define ACC_RST 8'h00

// pc step past a two-byte instruction
`define PC_STEP2 16'h0002

`endif

// *** src/exec_ops.v ***
`timescale 1ns/1ns
`default_nettype none
`include "exec_ops_map.vh"

// Summary of operation
// RULE1 - push: increment pointer, then write byte
// RULE2 - return: pop high, then low byte
// RULE3 - interrupt return also releases serviced priority
// RULE4 - interrupt return touches only pc, pointer
// RULE5 - one instruction runs before pending interrupt
// RULE6 - rotate left, bit7 to bit0, flags kept
// RULE7 - rotate left through carry, nine-bit ring
// RULE8 - rotate right, bit0 to bit7, flags kept
// RULE9 - rotate right through carry, nine-bit ring
// RULE10 - set bit: carry or addressable bit
// RULE11 - short jump: pc plus two plus displacement
// RULE12 - subtract with borrow, carry is borrow out
// RULE13 - auxiliary carry is borrow from bit three
// RULE14 - overflow flag is borrow six xor seven
// RULE15 - four source modes, one cycle each
// RULE16 - stack pointer wraps modulo 256
module exec_ops
(
  // clock, reset, enable
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_ce,
  // instruction request
  input wire i_op_valid,
  input wire [7:0] i_opcode,
  input wire [7:0] i_operand,
  input wire [15:0] i_pc,
  input wire [7:0] i_src_data,
  output wire o_ready,
  output wire [1:0] o_src_mode,
  output reg o_done,
  output reg o_unsupported,
  // internal data ram, asynchronous read
  output wire [7:0] o_ram_addr,
  output wire [7:0] o_ram_wdata,
  output wire o_ram_we,
  output wire o_ram_re,
  input wire [7:0] i_ram_rdata,
  // program counter load
  output reg o_pc_load,
  output reg [15:0] o_pc_target,
  // bit set request
  output reg o_bit_set,
  output reg [7:0] o_bit_addr,
  // interrupt priority logic
  input wire i_irq_pending,
  output reg o_prio_release,
  output wire o_irq_allow,
  // architectural state
  output wire [7:0] o_acc,
  output wire o_carry,
  output wire o_aux_carry,
  output wire o_ovf,
  output wire [7:0] o_stack_pointer
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_PUSH_WR = 2'h1;
  localparam [1:0] ST_POP_LO = 2'h2;
  localparam [1:0] ST_JMP = 2'h3;

  reg [1:0] state_q;
  reg [7:0] sp_q;
  reg [7:0] acc_q;
  reg cy_q;
  reg ac_q;
  reg ov_q;
  reg [7:0] data_q;
  reg int_exit_q;
  reg hold_q;

  wire accept;
  wire is_subtract_with_borrow;
  wire [10:0] sub_res;
  reg [1:0] src_mode_c;

  // {result, borrow7, borrow3, overflow}
  function [10:0] sub_borrow;
    input [7:0] a;
    input [7:0] s;
    input c;
    reg [8:0] full;
    reg [4:0] low4;
    reg [7:0] low7;
    begin
      full = {1'b0, a} - {1'b0, s} - {8'h00, c};
      low4 = {1'b0, a[3:0]} - {1'b0, s[3:0]} - {4'h0, c};
      low7 = {1'b0, a[6:0]} - {1'b0, s[6:0]} - {7'h00, c};
      sub_borrow = {full[7:0], full[8], low4[4], low7[7] ^ full[8]};
    end
  endfunction

  // opcode classes, shared by the ram strobe, the mode output and the execute step
  function is_return;
    input [7:0] op;
    begin
      is_return = (op == `OP_SUB_EXIT) || (op == `OP_INT_EXIT);
    end
  endfunction

  function is_subtract_with_borrow_reg;
    input [7:0] op;
    begin
      is_subtract_with_borrow_reg = (op[7:3] == `OP_SUBTRACT_WITH_BORROW_REG_HI);
    end
  endfunction

  function is_subtract_with_borrow_ind;
    input [7:0] op;
    begin
      is_subtract_with_borrow_ind = (op == `OP_SUBTRACT_WITH_BORROW_IND0) || (op == `OP_SUBTRACT_WITH_BORROW_IND1);
    end
  endfunction

  assign o_ready = (state_q == ST_IDLE);
  assign accept = i_op_valid & o_ready;
  assign is_subtract_with_borrow = is_subtract_with_borrow_reg(i_opcode) || is_subtract_with_borrow_ind(i_opcode) ||
                   (i_opcode == `OP_SUBTRACT_WITH_BORROW_IMM) || (i_opcode == `OP_SUBTRACT_WITH_BORROW_DIR);
  assign sub_res = sub_borrow(acc_q, i_src_data, cy_q);

  // tells the operand fetch where the source byte comes from; decoded from the
  // raw opcode so the fetch can finish in the same cycle as the request
  always @*
  begin
    if (is_subtract_with_borrow_reg(i_opcode))
    begin
      src_mode_c = `SRC_REG; // RULE15
    end
    else if (i_opcode == `OP_SUBTRACT_WITH_BORROW_IMM)
    begin
      src_mode_c = `SRC_IMM; // RULE15
    end
    else if (is_subtract_with_borrow_ind(i_opcode))
    begin
      src_mode_c = `SRC_IND; // RULE15
    end
    else
    begin
      src_mode_c = `SRC_DIR; // RULE15
    end
  end

  assign o_src_mode = src_mode_c;

  // return reads the stack at the current pointer both cycles
  assign o_ram_addr = sp_q;
  assign o_ram_wdata = data_q;
  assign o_ram_we = (state_q == ST_PUSH_WR); // RULE1
  assign o_ram_re = (state_q == ST_POP_LO) || (accept && is_return(i_opcode));

  // interrupts are held off while busy and for one instruction after an interrupt return
  assign o_irq_allow = ~hold_q & o_ready; // RULE5

  assign o_acc = acc_q;
  assign o_carry = cy_q;
  assign o_aux_carry = ac_q;
  assign o_ovf = ov_q;
  assign o_stack_pointer = sp_q;

  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_q <= ST_IDLE;
      sp_q <= `SP_RST;
      acc_q <= `ACC_RST;
      cy_q <= 1'b0;
      ac_q <= 1'b0;
      ov_q <= 1'b0;
      data_q <= 8'h00;
      int_exit_q <= 1'b0;
      hold_q <= 1'b0;
      o_done <= 1'b0;
      o_unsupported <= 1'b0;
      o_pc_load <= 1'b0;
      o_pc_target <= 16'h0000;
      o_bit_set <= 1'b0;
      o_bit_addr <= 8'h00;
      o_prio_release <= 1'b0;
    end
    else if (i_ce)
    begin
      o_done <= 1'b0;
      o_unsupported <= 1'b0;
      o_pc_load <= 1'b0;
      o_bit_set <= 1'b0;
      o_prio_release <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (accept)
          begin
            if (i_opcode == `OP_PUSH)
            begin
              sp_q <= sp_q + 8'h01; // RULE1 RULE16
              data_q <= i_src_data;
              state_q <= ST_PUSH_WR;
            end
            else if (is_return(i_opcode))
            begin
              // RULE2 RULE4
              o_pc_target[15:8] <= i_ram_rdata;
              sp_q <= sp_q - 8'h01; // RULE16
              int_exit_q <= (i_opcode == `OP_INT_EXIT);
              state_q <= ST_POP_LO;
            end
            else if (i_opcode == `OP_SHORT_RELATIVE_JUMP)
            begin
              o_pc_target <= i_pc + `PC_STEP2 + {{8{i_operand[7]}}, i_operand}; // RULE11
              state_q <= ST_JMP;
            end
            else
            begin
              // single-cycle group completes at this edge
              o_done <= 1'b1;
              hold_q <= 1'b0; // RULE5
              if (i_opcode == `OP_ROT_L)
              begin
                acc_q <= {acc_q[6:0], acc_q[7]}; // RULE6
              end
              else if (i_opcode == `OP_ROT_LC)
              begin
                acc_q <= {acc_q[6:0], cy_q}; // RULE7
                cy_q <= acc_q[7];
              end
              else if (i_opcode == `OP_ROT_R)
              begin
                acc_q <= {acc_q[0], acc_q[7:1]}; // RULE8
              end
              else if (i_opcode == `OP_ROT_RC)
              begin
                acc_q <= {cy_q, acc_q[7:1]}; // RULE9
                cy_q <= acc_q[0];
              end
              else if (i_opcode == `OP_SET_BIT_OP_C)
              begin
                cy_q <= 1'b1; // RULE10
              end
              else if (i_opcode == `OP_SET_BIT_OP_BIT)
              begin
                o_bit_set <= 1'b1; // RULE10
                o_bit_addr <= i_operand;
              end
              else if (is_subtract_with_borrow)
              begin
                acc_q <= sub_res[10:3]; // RULE12 RULE15
                cy_q <= sub_res[2]; // RULE12
                ac_q <= sub_res[1]; // RULE13
                ov_q <= sub_res[0]; // RULE14
              end
              else
              begin
                // not handled here; completes with no effect
                o_unsupported <= 1'b1;
              end
            end
          end
        end
        ST_PUSH_WR:
        begin
          o_done <= 1'b1;
          hold_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        ST_POP_LO:
        begin
          o_pc_target[7:0] <= i_ram_rdata; // RULE2
          sp_q <= sp_q - 8'h01; // RULE2 RULE16
          o_pc_load <= 1'b1;
          o_done <= 1'b1;
          o_prio_release <= int_exit_q; // RULE3
          // a pending request of any level waits one instruction
          hold_q <= int_exit_q; // RULE5
          state_q <= ST_IDLE;
        end
        ST_JMP:
        begin
          o_pc_load <= 1'b1; // RULE11
          o_done <= 1'b1;
          hold_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // pending level is only consumed by the priority logic through o_irq_allow
  wire unused_pending;
  assign unused_pending = i_irq_pending;

endmodule

`default_nettype wire

// *** verif/exec_stack_ram.sv ***
`timescale 1ns/1ns
`default_nettype none
module exec_stack_ram (
  // port to the block
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  always @(posedge i_clk) if (i_we) mem[i_addr] <= i_wdata;
  always @(posedge i_clk) if (i_re) last <= mem[i_addr];
  // outside a read the bus shows garbage, never a stale byte
  assign o_rdata = i_re ? mem[i_addr] : ~last;
endmodule
`default_nettype wire

// *** verif/exec_ops_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "exec_ops_map.vh"
module exec_ops_checker (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_op_valid,
  input wire [7:0] i_opcode,
  input wire o_ready,
  input wire o_done,
  input wire o_ram_we,
  input wire [7:0] o_ram_addr,
  input wire [7:0] o_stack_pointer,
  input wire o_pc_load,
  input wire o_prio_release,
  input wire [7:0] o_acc,
  input wire o_carry,
  input wire o_irq_allow,
  input wire [1:0] o_src_mode
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  wire k = i_op_valid & o_ready;
  property p_push; k && i_opcode == `OP_PUSH |=>
    o_ram_we && o_ram_addr == $past(o_stack_pointer) + 8'h01 ##1 o_done; endproperty
  a_push: assert property (p_push) else $error("push");
  property p_ret; k && i_opcode == `OP_SUB_EXIT |->
    ##2 o_pc_load && o_stack_pointer + 8'h02 == $past(o_stack_pointer, 2); endproperty
  a_ret: assert property (p_ret) else $error("return");
  property p_interrupt_exit_op; k && i_opcode == `OP_INT_EXIT |-> ##2 o_prio_release; endproperty
  a_interrupt_exit_op: assert property (p_interrupt_exit_op) else $error("release");
  property p_rl; k && i_opcode == `OP_ROT_L |=>
    o_acc == $past({o_acc[6:0], o_acc[7]}) && $stable(o_carry); endproperty
  a_rl: assert property (p_rl) else $error("rot l");
  property p_rlc; k && i_opcode == `OP_ROT_LC |=>
    {o_carry, o_acc} == $past({o_acc, o_carry}); endproperty
  a_rlc: assert property (p_rlc) else $error("rot lc");
  property p_rr; k && i_opcode == `OP_ROT_R |=>
    o_acc == $past({o_acc[0], o_acc[7:1]}) && $stable(o_carry); endproperty
  a_rr: assert property (p_rr) else $error("rot r");
  property p_rrc; k && i_opcode == `OP_ROT_RC |=>
    {o_acc, o_carry} == $past({o_carry, o_acc}); endproperty
  a_rrc: assert property (p_rrc) else $error("rot rc");
  property p_set_bit_op; k && i_opcode == `OP_SET_BIT_OP_C |=> o_carry && o_done; endproperty
  a_set_bit_op: assert property (p_set_bit_op) else $error("set_bit_op");
  property p_interrupt_exit_op_keep; k && i_opcode == `OP_INT_EXIT |->
    ##2 o_acc == $past(o_acc, 2) && o_carry == $past(o_carry, 2); endproperty
  a_interrupt_exit_op_keep: assert property (p_interrupt_exit_op_keep) else $error("return changed state");
  property p_hold; o_prio_release |-> !o_irq_allow; endproperty
  a_hold: assert property (p_hold) else $error("interrupts allowed after return");
  property p_allow; o_done && !o_prio_release |-> o_irq_allow; endproperty
  a_allow: assert property (p_allow) else $error("interrupts still held");
  property p_src_reg; k && i_opcode[7:3] == `OP_SUBTRACT_WITH_BORROW_REG_HI |-> o_src_mode == `SRC_REG;
  endproperty
  a_src_reg: assert property (p_src_reg) else $error("register source mode");
  property p_src_mem; k && (i_opcode == `OP_SUBTRACT_WITH_BORROW_IMM || i_opcode == `OP_SUBTRACT_WITH_BORROW_DIR) |->
    o_src_mode == (i_opcode == `OP_SUBTRACT_WITH_BORROW_IMM ? `SRC_IMM : `SRC_DIR); endproperty
  a_src_mem: assert property (p_src_mem) else $error("byte source mode");
  property p_src_ind; k && (i_opcode == `OP_SUBTRACT_WITH_BORROW_IND0 || i_opcode == `OP_SUBTRACT_WITH_BORROW_IND1) |->
    o_src_mode == `SRC_IND; endproperty
  a_src_ind: assert property (p_src_ind) else $error("indirect source mode");
endmodule
bind exec_ops exec_ops_checker i_chk (.i_sys_clk, .i_rstn, .i_op_valid, .i_opcode,
  .o_ready, .o_done, .o_ram_we, .o_ram_addr, .o_stack_pointer, .o_pc_load,
  .o_prio_release, .o_acc, .o_carry, .o_irq_allow, .o_src_mode);
`default_nettype wire

// *** verif/exec_ops_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "exec_ops_map.vh"
module exec_ops_tb_top;
  logic i_sys_clk = 1'b0, i_rstn = 1'b0, i_op_valid = 1'b0;
  logic [7:0] i_opcode = 8'h00, i_operand = 8'h00, i_src_data = 8'h00;
  logic [15:0] i_pc = 16'h0000;
  wire o_ready, o_done, o_ram_we, o_ram_re, o_pc_load, o_bit_set, o_carry, o_aux_carry, o_ovf;
  wire o_unsupported;
  wire [7:0] o_ram_addr, o_ram_wdata, i_ram_rdata, o_bit_addr, o_acc, o_stack_pointer;
  wire [15:0] o_pc_target;
  logic [7:0] a = 8'h00, sp = `SP_RST, ba = 8'h00, m [256];
  logic c = 1'b0, h = 1'b0, v = 1'b0, pl, bs, u;
  logic [15:0] t = 16'h0000;
  logic [45:0] exp_q [$];
  // 8'h00 lies outside this block's set and must complete with no effect
  logic [7:0] tbl [15] = '{`OP_PUSH, `OP_SUB_EXIT, `OP_INT_EXIT, `OP_ROT_L, `OP_ROT_LC,
    `OP_ROT_R, `OP_ROT_RC, `OP_SET_BIT_OP_C, `OP_SET_BIT_OP_BIT, `OP_SHORT_RELATIVE_JUMP, `OP_SUBTRACT_WITH_BORROW_IMM, `OP_SUBTRACT_WITH_BORROW_DIR,
    `OP_SUBTRACT_WITH_BORROW_IND0, `OP_SUBTRACT_WITH_BORROW_IND1, 8'h00};
  int error_cnt = 0, n_tests = 0;
  always #50 i_sys_clk = ~i_sys_clk;
  exec_ops i_dut (.i_sys_clk, .i_rstn, .i_ce(1'b1), .i_op_valid, .i_opcode, .i_operand,
    .i_pc, .i_src_data, .o_ready, .o_src_mode(), .o_done, .o_unsupported, .o_ram_addr,
    .o_ram_wdata, .o_ram_we, .o_ram_re, .i_ram_rdata, .o_pc_load, .o_pc_target, .o_bit_set,
    .o_bit_addr, .i_irq_pending(1'b0), .o_prio_release(), .o_irq_allow(), .o_acc, .o_carry,
    .o_aux_carry, .o_ovf, .o_stack_pointer);
  exec_stack_ram i_ram (.i_clk(i_sys_clk), .i_we(o_ram_we), .i_re(o_ram_re),
    .i_addr(o_ram_addr), .i_wdata(o_ram_wdata), .o_rdata(i_ram_rdata));
  task end_of_test;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task fail(input string s);
    error_cnt++;
    $display("ERROR %0t %s", $time, s);
  endtask
  // called on a rising edge; returns on the edge that takes the request
  task op(input logic [7:0] x);
    logic [8:0] r;
    logic [7:0] w, d, s;
    logic [4:0] q;
    logic [15:0] p;
    int n;
    d = 8'($urandom);
    s = 8'($urandom);
    p = 16'($urandom);
    pl = 1'b0;
    bs = 1'b0;
    u = 1'b0;
    i_op_valid <= 1'b1;
    i_opcode <= x;
    i_operand <= d;
    i_src_data <= s;
    i_pc <= p;
    case (x)
      `OP_PUSH: begin sp = sp + 8'h01; m[sp] = s; end
      `OP_SUB_EXIT, `OP_INT_EXIT: begin t = {m[sp], m[sp - 8'h01]}; sp = sp - 8'h02; pl = 1; end
      `OP_ROT_L: a = {a[6:0], a[7]};
      `OP_ROT_LC: {c, a} = {a, c};
      `OP_ROT_R: a = {a[0], a[7:1]};
      `OP_ROT_RC: {a, c} = {c, a};
      `OP_SET_BIT_OP_C: c = 1'b1;
      `OP_SET_BIT_OP_BIT: begin ba = d; bs = 1'b1; end
      `OP_SHORT_RELATIVE_JUMP: begin t = p + `PC_STEP2 + {{8{d[7]}}, d}; pl = 1'b1; end
      8'h00: u = 1'b1;
      default:
      begin
        r = {1'b0, a} - s - c;
        q = {1'b0, a[3:0]} - s[3:0] - c;
        w = {1'b0, a[6:0]} - s[6:0] - c;
        {c, h, v, a} = {r[8], q[4], r[8] ^ w[7], r[7:0]};
      end
    endcase
    exp_q.push_back({a, c, h, v, sp, pl, t, bs, ba, u});
    n = 0;
    do
    begin
      @(negedge i_sys_clk) r[0] = o_ready;
      @(posedge i_sys_clk) n++;
    end while (r[0] !== 1'b1 && n < 9);
    if (r[0] !== 1'b1)
    begin
      fail("request never taken");
      end_of_test();
    end
  endtask
  task check_state(input logic [45:0] e);
    n_tests++;
    if ({o_acc, o_carry, o_aux_carry, o_ovf, o_stack_pointer, o_pc_load, o_pc_target,
      o_bit_set, o_bit_addr, o_unsupported} !== e)
      fail("state after instruction differs");
  endtask
  always @(negedge i_sys_clk)
    if (i_rstn && o_done === 1'b1)
    begin
      if (exp_q.size() == 0)
        fail("unexpected done");
      else
        check_state(exp_q.pop_front());
    end
  initial
  begin
    void'($urandom(58));
    repeat (16) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    @(posedge i_sys_clk);
    repeat (256) op(`OP_PUSH);
    $display("stack fill done");
    repeat (400) op($urandom_range(0, 15) == 15 ? {`OP_SUBTRACT_WITH_BORROW_REG_HI, 3'($urandom)} :
      tbl[$urandom_range(0, 14)]);
    i_op_valid <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    if (exp_q.size() != 0)
      fail("instructions left unfinished");
    $display("random instruction mix done");
    end_of_test();
  end
endmodule
`default_nettype wire
